// ### hdl/tcu_pkg.sv
// Purpose: Shared constants and helpers for the timer capture compare unit
// Assumes: Byte wide register port, one 100 MHz bus clock
// Notes:   Control bits 4 and 3 are unused and read zero
package tcu_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TCU_OFS_CONTROL     = 8'h12;
  localparam logic [7:0] TCU_OFS_FLAGS       = 8'h13;
  localparam logic [7:0] TCU_OFS_CAP_HIGH    = 8'h14;
  localparam logic [7:0] TCU_OFS_CAP_LOW     = 8'h15;
  localparam logic [7:0] TCU_OFS_CMP_HIGH    = 8'h16;
  localparam logic [7:0] TCU_OFS_CMP_LOW     = 8'h17;
  localparam logic [7:0] TCU_OFS_CNT_HIGH    = 8'h18;
  localparam logic [7:0] TCU_OFS_CNT_LOW     = 8'h19;
  localparam logic [7:0] TCU_OFS_MIRROR_HIGH = 8'h1a;
  localparam logic [7:0] TCU_OFS_MIRROR_LOW  = 8'h1b;

  // ----------------------------------------------------------------------
  // Control field positions and reset value
  // ----------------------------------------------------------------------
  localparam int         TCU_CTL_SNAP_IE  = 7;
  localparam int         TCU_CTL_MATCH_IE = 6;
  localparam int         TCU_CTL_WRAP_IE  = 5;
  localparam int         TCU_CTL_RUN      = 2;
  localparam int         TCU_CTL_EDGE     = 1;
  localparam int         TCU_CTL_LEVEL    = 0;
  localparam logic [7:0] TCU_CTL_MASK     = 8'he7;
  localparam logic [7:0] TCU_CTL_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // Flag vector: index 2 snapshot, 1 match, 0 wrap; sits in bits 7..5
  // ----------------------------------------------------------------------
  localparam int         TCU_FLG_SNAP  = 2;
  localparam int         TCU_FLG_MATCH = 1;
  localparam int         TCU_FLG_WRAP  = 0;
  localparam logic [2:0] TCU_FLG_RESET = 3'h0;
  localparam logic [4:0] TCU_FLG_PAD   = 5'h00;

  // ----------------------------------------------------------------------
  // Counter and prescaler
  // ----------------------------------------------------------------------
  localparam logic [15:0] TCU_CNT_RESET  = 16'hfffc;
  localparam logic [15:0] TCU_CNT_MAX    = 16'hffff;
  localparam logic [15:0] TCU_CNT_ONE    = 16'h0001;
  localparam int          TCU_PRESC_DIV  = 4;
  localparam logic [1:0]  TCU_PRESC_LAST = 2'(TCU_PRESC_DIV - 1);
  localparam logic [1:0]  TCU_PRESC_ONE  = 2'h1;
  localparam logic [1:0]  TCU_SYNC_PRIME = 2'h3;

  function automatic logic [7:0] tcu_hi(input logic [15:0] v);
    tcu_hi = v[15:8];
  endfunction

  function automatic logic [7:0] tcu_lo(input logic [15:0] v);
    tcu_lo = v[7:0];
  endfunction

endpackage

// ### hdl/tcu_edge_sync.sv
// Purpose: Synchronise the snapshot pin and detect the selected edge
// Assumes: Pin is asynchronous to clk
// Notes:   Edges are ignored until the chain has been primed after reset
`timescale 1ns/1ps
`default_nettype none
module tcu_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rising_sel,
  // Detected edge
  output logic      edge_pulse
);
  import tcu_pkg::*;

  logic       s1_ff;
  logic       s2_ff;
  logic       s3_ff;
  logic [1:0] prime_ff;
  logic       pulse_ff;
  wire        primed = (prime_ff == TCU_SYNC_PRIME);
  wire        rise   = s2_ff & ~s3_ff;
  wire        fall   = ~s2_ff & s3_ff;
  wire        nxt_pulse = primed & (rising_sel ? rise : fall);

  // ----------------------------------------------------------------------
  // Two stage synchroniser, then history stage for the edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff    <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      prime_ff <= 2'h0;
      pulse_ff <= 1'b0;
    end else begin
      s1_ff    <= pin;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      prime_ff <= primed ? prime_ff : prime_ff + TCU_PRESC_ONE;
      pulse_ff <= nxt_pulse;
    end
  end

  assign edge_pulse = pulse_ff;

endmodule
`default_nettype wire

// ### hdl/tcu_timer_capture_compare.sv
// Purpose: 16-bit free running timer with one compare and one capture
// Assumes: Byte register port with read data one cycle after the strobe
// Notes:   Compare and capture data registers are not reset on purpose
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_capture_compare (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Processor mode and pin routing
  input  wire logic       stop_mode,
  input  wire logic       match_pin_route_enable,
  // Port B timer pins
  input  wire logic       port_b_bit7,
  output logic            port_b_bit6,
  output logic            port_b_bit6_timer_sel,
  // Interrupt request
  output logic            timer_irq
);
  import tcu_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  ctl_ff;
  logic [2:0]  flag_ff;
  logic [2:0]  arm_ff;
  logic [15:0] cnt_ff;
  logic [1:0]  presc_ff;
  logic        step_ff;
  logic [7:0]  cmp_hi_ff;
  logic [7:0]  cmp_lo_ff;
  logic        cmp_inhibit_ff;
  logic        cmp_hi_seen_ff;
  logic        cmp_lo_seen_ff;
  logic        level_ff;
  logic        route_ff;
  logic [15:0] cap_ff;
  logic        cap_inhibit_ff;
  logic [15:0] cnt_d1_ff;
  logic [15:0] cnt_d2_ff;
  logic [15:0] pend_ff;
  logic        pend_valid_ff;
  logic [7:0]  buf_ff;
  logic        buf_held_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic [7:0]  nxt_rdata;
  logic        edge_pulse;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire hit_ctl    = (reg_addr == TCU_OFS_CONTROL);
  wire hit_flags  = (reg_addr == TCU_OFS_FLAGS);
  wire hit_cap_hi = (reg_addr == TCU_OFS_CAP_HIGH);
  wire hit_cap_lo = (reg_addr == TCU_OFS_CAP_LOW);
  wire hit_cmp_hi = (reg_addr == TCU_OFS_CMP_HIGH);
  wire hit_cmp_lo = (reg_addr == TCU_OFS_CMP_LOW);
  wire hit_cnt_hi = (reg_addr == TCU_OFS_CNT_HIGH);
  wire hit_cnt_lo = (reg_addr == TCU_OFS_CNT_LOW);
  wire hit_mir_hi = (reg_addr == TCU_OFS_MIRROR_HIGH);
  wire hit_mir_lo = (reg_addr == TCU_OFS_MIRROR_LOW);
  wire access     = reg_rd | reg_wr;

  wire wr_ctl     = reg_wr & hit_ctl;
  wire wr_cmp_hi  = reg_wr & hit_cmp_hi;
  wire wr_cmp_lo  = reg_wr & hit_cmp_lo;
  wire rd_cap_hi  = reg_rd & hit_cap_hi;
  wire rd_cap_lo  = reg_rd & hit_cap_lo;
  wire rd_any_hi  = reg_rd & (hit_cnt_hi | hit_mir_hi);
  wire rd_any_lo  = reg_rd & (hit_cnt_lo | hit_mir_lo);
  wire acc_flags  = access & hit_flags;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire       ctl_run   = ctl_ff[TCU_CTL_RUN];
  wire       ctl_edge  = ctl_ff[TCU_CTL_EDGE];
  wire       ctl_level = ctl_ff[TCU_CTL_LEVEL];
  wire [2:0] ctl_ie    = {ctl_ff[TCU_CTL_SNAP_IE], ctl_ff[TCU_CTL_MATCH_IE],
                          ctl_ff[TCU_CTL_WRAP_IE]};
  // Interrupt follows the enables being written, so it never lags a cycle
  wire [7:0] nxt_ctl   = wr_ctl ? (reg_wdata & TCU_CTL_MASK) : ctl_ff;
  wire [2:0] nxt_ie    = {nxt_ctl[TCU_CTL_SNAP_IE], nxt_ctl[TCU_CTL_MATCH_IE],
                          nxt_ctl[TCU_CTL_WRAP_IE]};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_ff <= TCU_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_ff <= reg_wdata & TCU_CTL_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------------
  // Counter ignores wait mode, so it simply keeps running there.
  wire count_tick = ctl_run & ~stop_mode & (presc_ff == TCU_PRESC_LAST);
  wire wrap_evt   = count_tick & (cnt_ff == TCU_CNT_MAX);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff   <= TCU_CNT_RESET;
      presc_ff <= 2'h0;
      step_ff  <= 1'b0;
    end else if (!ctl_run) begin
      cnt_ff   <= TCU_CNT_RESET;
      presc_ff <= 2'h0;
      step_ff  <= 1'b0;
    end else if (!stop_mode) begin
      presc_ff <= presc_ff + TCU_PRESC_ONE;
      step_ff  <= count_tick;
      if (count_tick) begin
        cnt_ff <= cnt_ff + TCU_CNT_ONE;
      end
    end else begin
      step_ff  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // Not reset, so the bytes can double as storage across a reset.
  always_ff @(posedge clk) begin
    if (wr_cmp_hi) begin
      cmp_hi_ff <= reg_wdata;
    end
    if (wr_cmp_lo) begin
      cmp_lo_ff <= reg_wdata;
    end
  end

  // Match only on the cycle after a step, so one count gives one match.
  wire cmp_active = ~cmp_inhibit_ff & cmp_hi_seen_ff & cmp_lo_seen_ff;
  wire match_evt  = step_ff & cmp_active &
                    (cnt_ff == {cmp_hi_ff, cmp_lo_ff});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_inhibit_ff <= 1'b0;
      cmp_hi_seen_ff <= 1'b0;
      cmp_lo_seen_ff <= 1'b0;
      level_ff       <= 1'b0;
      route_ff       <= 1'b0;
    end else begin
      if (wr_cmp_hi) begin
        cmp_inhibit_ff <= 1'b1;
        cmp_hi_seen_ff <= 1'b1;
      end else if (wr_cmp_lo) begin
        cmp_inhibit_ff <= 1'b0;
        cmp_lo_seen_ff <= 1'b1;
      end
      if (match_evt) begin
        level_ff <= ctl_level;
      end
      route_ff <= match_pin_route_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  tcu_edge_sync u_edge (
    .clk        (clk),
    .reset      (reset),
    .pin        (port_b_bit7),
    .rising_sel (ctl_edge),
    .edge_pulse (edge_pulse)
  );

  // The pulse trails the pin by the synchroniser, so the count is taken
  // from the delay line and stepped by one.
  wire [15:0] cap_src  = cnt_d2_ff + TCU_CNT_ONE;
  wire        cap_live = edge_pulse & ctl_run & ~stop_mode;
  wire        cap_arm  = edge_pulse & ctl_run & stop_mode & ~pend_valid_ff;
  wire        cap_wake = pend_valid_ff & ~stop_mode;
  wire        cap_new  = cap_live & ~cap_inhibit_ff;

  always_ff @(posedge clk) begin
    if (cap_new) begin
      cap_ff <= cap_src;
    end else if (cap_wake) begin
      cap_ff <= pend_ff;
    end
    if (cap_arm) begin
      pend_ff <= cap_src;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_d1_ff      <= TCU_CNT_RESET;
      cnt_d2_ff      <= TCU_CNT_RESET;
      pend_valid_ff  <= 1'b0;
      cap_inhibit_ff <= 1'b0;
    end else begin
      cnt_d1_ff <= cnt_ff;
      cnt_d2_ff <= cnt_d1_ff;
      if (cap_arm) begin
        pend_valid_ff <= 1'b1;
      end else if (cap_wake) begin
        pend_valid_ff <= 1'b0;
      end
      if (rd_cap_hi) begin
        cap_inhibit_ff <= 1'b1;
      end else if (rd_cap_lo) begin
        cap_inhibit_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flags, two step clear, interrupt
  // ----------------------------------------------------------------------
  // A set in the clearing cycle wins, and the flag must be re-armed.
  wire [2:0] flag_set = {cap_live | cap_wake, match_evt, wrap_evt};
  wire [2:0] flag_clr = arm_ff & {access & hit_cap_lo,
                                  access & hit_cmp_lo,
                                  access & hit_cnt_lo};
  wire [2:0] nxt_flag = flag_set | (flag_ff & ~flag_clr);
  wire [2:0] nxt_arm  = nxt_flag & ~flag_clr &
                        (arm_ff | ({3{acc_flags}} & flag_ff));
  wire       nxt_irq  = |(nxt_flag & nxt_ie);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_ff <= TCU_FLG_RESET;
      arm_ff  <= TCU_FLG_RESET;
      irq_ff  <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      arm_ff  <= nxt_arm;
      irq_ff  <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Count read buffer and read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_ff      <= 8'h00;
      buf_held_ff <= 1'b0;
    end else if (rd_any_hi && !buf_held_ff) begin
      buf_ff      <= tcu_lo(cnt_ff);
      buf_held_ff <= 1'b1;
    end else if (rd_any_lo) begin
      buf_held_ff <= 1'b0;
    end
  end

  wire [7:0] cnt_lo_view = buf_held_ff ? buf_ff : tcu_lo(cnt_ff);

  always_comb begin
    nxt_rdata = 8'h00;
    if (!reg_rd) begin
      nxt_rdata = 8'h00;
    end else if (hit_ctl) begin
      nxt_rdata = ctl_ff;
    end else if (hit_flags) begin
      nxt_rdata = {flag_ff, TCU_FLG_PAD};
    end else if (hit_cap_hi) begin
      nxt_rdata = tcu_hi(cap_ff);
    end else if (hit_cap_lo) begin
      nxt_rdata = tcu_lo(cap_ff);
    end else if (hit_cmp_hi) begin
      nxt_rdata = cmp_hi_ff;
    end else if (hit_cmp_lo) begin
      nxt_rdata = cmp_lo_ff;
    end else if (hit_cnt_hi || hit_mir_hi) begin
      nxt_rdata = tcu_hi(cnt_ff);
    end else if (hit_cnt_lo || hit_mir_lo) begin
      nxt_rdata = cnt_lo_view;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata             = rdata_ff;
  assign port_b_bit6           = level_ff;
  assign port_b_bit6_timer_sel = route_ff;
  assign timer_irq             = irq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_flags_pad_zero: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && hit_flags) |=> (reg_rdata[4:0] == 5'h00))
    else $error("flags low bits not zero");

  chk_match_sets_flag: assert property (
    @(posedge clk) disable iff (reset)
    match_evt |=> flag_ff[TCU_FLG_MATCH])
    else $error("match did not set flag");

  chk_level_on_match: assert property (
    @(posedge clk) disable iff (reset)
    match_evt |=> (port_b_bit6 == $past(ctl_level)))
    else $error("pin level not taken on match");

  chk_hi_write_blocks: assert property (
    @(posedge clk) disable iff (reset)
    wr_cmp_hi ##1 (!wr_cmp_lo)[*2] |-> !match_evt)
    else $error("match while compare high pending");

  chk_wrap_to_zero: assert property (
    @(posedge clk) disable iff (reset)
    wrap_evt |=> (flag_ff[TCU_FLG_WRAP] && cnt_ff == 16'h0000))
    else $error("wrap flag or count wrong");

  chk_run_off_hold: assert property (
    @(posedge clk) disable iff (reset)
    !ctl_run |=> (cnt_ff == TCU_CNT_RESET))
    else $error("counter moved while off");

  chk_step_spacing: assert property (
    @(posedge clk) disable iff (reset)
    count_tick |=> !count_tick [*3])
    else $error("counter stepped faster than four");

  chk_capture_blocked: assert property (
    @(posedge clk) disable iff (reset)
    (cap_inhibit_ff && !cap_wake) |=> $stable(cap_ff))
    else $error("capture changed while blocked");

  chk_irq_gating: assert property (
    @(posedge clk) disable iff (reset)
    ##1 (timer_irq == |(flag_ff & ctl_ie)))
    else $error("interrupt not flag and enable");

endmodule
`default_nettype wire

// ### tb/tcu_pin_model.sv
// Purpose: Far side of the timer pins, drives the snapshot pin
// Assumes: Pin changes launch just after a rising clock edge
// Notes:   Counts rising edges on the compare pin while it is routed
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
  // Clock
  input  wire logic clk,
  // Timer pins
  input  wire logic match_pin,
  input  wire logic match_sel,
  output logic      snap_pin,
  // Observation
  output int        match_rises
);
  logic last_ff;
  initial begin
    snap_pin = 1'b0;
    last_ff = 1'b0;
  end
  // ----------------------------------------------------------------------
  // Pin driver: one level change per call, held until the next call
  // ----------------------------------------------------------------------
  task automatic set_pin(input logic v);
    @(posedge clk);
    snap_pin <= v;
  endtask
  // ----------------------------------------------------------------------
  // Compare pin watch: an unrouted pin is not a timer output
  // ----------------------------------------------------------------------
  initial match_rises = 0;
  always @(posedge clk) begin
    last_ff <= match_pin;
    if (match_sel && match_pin && !last_ff) begin
      match_rises <= match_rises + 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/test_tcu_timer_capture_compare.sv
// Purpose: Self-checking bench for the timer capture compare unit
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Running counter figures are checked as small deltas; the reset preset and the stop-mode hold are checked exactly
`timescale 1ns/1ps
`default_nettype none
module test_tcu_timer_capture_compare;
  import tcu_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stop_mode;
  logic route;
  wire logic [7:0] reg_rdata;
  wire logic snap_pin;
  wire logic port_b_bit6;
  wire logic timer_sel;
  wire logic timer_irq;
  int match_rises;
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] exp_q[$];
  logic [7:0] mask_q[$];
  string name_q[$];
  logic rd_q = 1'b0;
  logic [7:0] last_rd;
  logic [7:0] note_e;
  logic [7:0] note_m;
  logic [7:0] c;
  logic [15:0] cmp;
  always #5 clk = ~clk;
  tcu_timer_capture_compare dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .match_pin_route_enable(route),
    .port_b_bit7(snap_pin), .port_b_bit6(port_b_bit6),
    .port_b_bit6_timer_sel(timer_sel), .timer_irq(timer_irq));
  tcu_pin_model model (
    .clk(clk), .match_pin(port_b_bit6), .match_sel(timer_sel),
    .snap_pin(snap_pin), .match_rises(match_rises));
  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One idle cycle after each strobe keeps drivers single per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    name_q.push_back($sformatf("reg %h", a));
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input logic pin_sel, input logic v);
    int n;
    logic s;
    n = 0;
    @(negedge clk);
    s = pin_sel ? port_b_bit6 : timer_irq;
    while (s !== v && n < 500) begin
      @(negedge clk);
      s = pin_sel ? port_b_bit6 : timer_irq;
      n++;
    end
    check(pin_sel ? "pin" : "irq", {7'h0, v}, {7'h0, s});
    @(posedge clk);
    if (n >= 500) end_of_test();
  endtask
  // ----------------------------------------------------------------------
  // Read data watcher: oldest note against the data cycle
  // ----------------------------------------------------------------------
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q) begin
      last_rd = reg_rdata;
      note_e = exp_q.pop_front();
      note_m = mask_q.pop_front();
      check(name_q.pop_front(), note_e & note_m, reg_rdata & note_m);
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(36));
    reg_addr <= 8'h00;
    reg_wdata <= 8'($urandom);
    stop_mode <= 1'b0;
    route <= 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(TCU_OFS_CONTROL, 8'h00, 8'hff);
    rd(TCU_OFS_FLAGS, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    wr(TCU_OFS_FLAGS, 8'hff);
    rd(TCU_OFS_FLAGS, 8'h00, 8'hff);
    wr(TCU_OFS_CONTROL, 8'hff);
    rd(TCU_OFS_CONTROL, TCU_CTL_MASK, 8'hff);
    wr(TCU_OFS_CONTROL, 8'h00);
    rd(TCU_OFS_CNT_HIGH, 8'hff, 8'hff);
    rd(TCU_OFS_CNT_LOW, 8'hfc, 8'hff);
    check("timer_sel", 8'h00, {7'h0, timer_sel});
    cmp = {4'h7, 12'($urandom)};
    wr(TCU_OFS_CMP_HIGH, cmp[15:8]);
    wr(TCU_OFS_CMP_LOW, cmp[7:0]);
    rd(TCU_OFS_CMP_HIGH, cmp[15:8], 8'hff);
    wr(TCU_OFS_CMP_LOW, ~cmp[7:0]);
    rd(TCU_OFS_CMP_HIGH, cmp[15:8], 8'hff);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(TCU_OFS_CMP_LOW, ~cmp[7:0], 8'hff);
    // Wrap from the preset, then the two-step clear
    wr(TCU_OFS_CONTROL, 8'h24);
    wait_for(1'b0, 1'b1);
    rd(TCU_OFS_FLAGS, 8'h20, 8'hff);
    rd(TCU_OFS_MIRROR_LOW, 8'h00, 8'h00);
    rd(TCU_OFS_MIRROR_HIGH, 8'h00, 8'hff);
    rd(TCU_OFS_FLAGS, 8'h20, 8'h20);
    rd(TCU_OFS_CNT_LOW, 8'h00, 8'h00);
    c = last_rd;
    rd(TCU_OFS_CNT_HIGH, 8'h00, 8'hff);
    repeat (40) @(posedge clk);
    rd(TCU_OFS_CNT_HIGH, 8'h00, 8'hff);
    rd(TCU_OFS_CNT_LOW, 8'h00, 8'h00);
    check("count buffer", 8'h01, {7'h0, (last_rd - c) <= 8'd3});
    rd(TCU_OFS_FLAGS, 8'h00, 8'h20);
    check("irq", 8'h00, {7'h0, timer_irq});
    // Compare: suspended by a lone high write, then matched twice
    route <= 1'b1;
    wr(TCU_OFS_CONTROL, 8'h45);
    check("timer_sel", 8'h01, {7'h0, timer_sel});
    rd(TCU_OFS_CNT_LOW, 8'h00, 8'h00);
    c = last_rd;
    wr(TCU_OFS_CMP_LOW, c + 8'd4);
    wr(TCU_OFS_CMP_HIGH, 8'h00);
    repeat (40) @(posedge clk);
    rd(TCU_OFS_FLAGS, 8'h00, 8'h40);
    wr(TCU_OFS_CMP_LOW, c + 8'd24);
    wait_for(1'b1, 1'b1);
    rd(TCU_OFS_FLAGS, 8'h40, 8'h40);
    check("rises", 8'h01, 8'(match_rises));
    check("irq", 8'h01, {7'h0, timer_irq});
    wr(TCU_OFS_CONTROL, 8'h44);
    wr(TCU_OFS_CMP_LOW, c + 8'd40);
    wait_for(1'b1, 1'b0);
    rd(TCU_OFS_FLAGS, 8'h40, 8'h40);
    rd(TCU_OFS_CMP_LOW, c + 8'd40, 8'hff);
    rd(TCU_OFS_FLAGS, 8'h00, 8'h40);
    check("irq", 8'h00, {7'h0, timer_irq});
    // Capture on rising edges, blocking and clearing
    wr(TCU_OFS_CONTROL, 8'h86);
    rd(TCU_OFS_CNT_LOW, 8'h00, 8'h00);
    c = last_rd;
    model.set_pin(1'b1);
    wait_for(1'b0, 1'b1);
    rd(TCU_OFS_FLAGS, 8'h80, 8'h80);
    rd(TCU_OFS_CAP_HIGH, 8'h00, 8'hff);
    rd(TCU_OFS_CAP_LOW, 8'h00, 8'h00);
    check("capture", 8'h01, {7'h0, (last_rd - c) <= 8'd2});
    c = last_rd;
    rd(TCU_OFS_CAP_HIGH, 8'h00, 8'hff);
    model.set_pin(1'b0);
    repeat (30) @(posedge clk);
    model.set_pin(1'b1);
    repeat (30) @(posedge clk);
    rd(TCU_OFS_CAP_LOW, c, 8'hff);
    model.set_pin(1'b0);
    repeat (30) @(posedge clk);
    model.set_pin(1'b1);
    repeat (30) @(posedge clk);
    rd(TCU_OFS_CAP_LOW, 8'h00, 8'h00);
    check("recapture", 8'h01, {7'h0, (last_rd - c) >= 8'd5});
    rd(TCU_OFS_FLAGS, 8'h80, 8'h80);
    rd(TCU_OFS_CAP_LOW, 8'h00, 8'h00);
    rd(TCU_OFS_FLAGS, 8'h00, 8'h80);
    model.set_pin(1'b0);
    repeat (30) @(posedge clk);
    rd(TCU_OFS_FLAGS, 8'h00, 8'h80);
    // Stop: counter halts, an edge is held back until wake
    stop_mode <= 1'b1;
    rd(TCU_OFS_CNT_LOW, 8'h00, 8'h00);
    c = last_rd;
    repeat (20) @(posedge clk);
    rd(TCU_OFS_CNT_LOW, c, 8'hff);
    model.set_pin(1'b1);
    repeat (30) @(posedge clk);
    rd(TCU_OFS_FLAGS, 8'h00, 8'h80);
    stop_mode <= 1'b0;
    repeat (10) @(posedge clk);
    rd(TCU_OFS_FLAGS, 8'h80, 8'h80);
    end_of_test();
  end
endmodule
`default_nettype wire
